// File: design/uotg_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
// hold timer request and expiry
interface uotg_cnt_if;
  logic run;
  logic done;
  modport owner (output run, input done);
  modport tmr   (input run, output done);
endinterface
`default_nettype wire

// File: design/uotg_hold_timer.sv
`timescale 1ns/1ps
`default_nettype none
module uotg_hold_timer #(
  parameter int LIMIT = 500
) (
  input  wire logic ref_clk,  // clock
  input  wire logic resetn,   // async reset
  uotg_cnt_if.tmr   ctl       // run level in, done level out
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  // count while run holds, saturate at the limit
  always_comb begin
    next_cnt = '0;
    if (ctl.run) begin
      next_cnt = (cnt == LIM) ? cnt : cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign ctl.done = (cnt == LIM);
endmodule // uotg_hold_timer
`default_nettype wire

// File: design/uotg_host_srp.sv
`timescale 1ns/1ps
`default_nettype none
module uotg_host_srp #(
  parameter int IDLE_CYCLES  = uotg_pkg::IDLE_CYCLES,
  parameter int FRAME_CYCLES = uotg_pkg::FRAME_CYCLES
) (
  input  wire logic        ref_clk,          // 200 MHz clock
  input  wire logic        resetn,           // async reset, active low
  input  wire logic [3:0]  avs_address,      // word index
  input  wire logic        avs_read,         // read request
  input  wire logic        avs_write,        // write request
  input  wire logic [31:0] avs_writedata,    // write data
  input  wire logic [3:0]  avs_byteenable,   // byte lanes
  output logic      [31:0] avs_readdata,     // read data
  output logic             avs_waitrequest,  // stall
  output logic             pkt_valid,        // transaction request
  input  wire logic        pkt_ready,        // link takes request
  output logic      [3:0]  pkt_pid,          // token pid
  output logic      [3:0]  pkt_endp,         // endpoint
  output logic      [6:0]  pkt_addr,         // target address
  output logic             pkt_toggle,       // data toggle
  output logic      [9:0]  pkt_count,        // byte count
  output logic      [15:0] pkt_buf_ptr,      // buffer pointer
  output logic             pkt_low_speed,    // low-speed signalling
  output logic             pkt_handshake,    // expect handshake
  input  wire logic        res_valid,        // transaction result
  input  wire logic [3:0]  res_pid,          // handshake or error
  input  wire logic [9:0]  res_count,        // bytes moved
  output logic             frame_start,      // frame pulse
  input  wire logic        line_dp,          // d-plus level pin
  input  wire logic        line_dm,          // d-minus level pin
  input  wire logic        vbus_sess_valid,  // comparator pin
  input  wire logic        vbus_sess_end,    // comparator pin
  output logic             dplus_pullup,     // d-plus pull-up
  output logic             dminus_pullup,    // d-minus pull-up
  output logic             vbus_power,       // vbus supply
  output logic             vbus_discharge,   // vbus resistor
  output logic             vbus_pulse        // vbus pulsing
);
  localparam int FW = $clog2(FRAME_CYCLES);
  localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);

  logic [7:0]  endpoint_zero_control, next_ep0;
  logic [7:0]  target_address_register, next_addr;
  logic [7:0]  token_issue_register, next_tok;
  logic [15:0] descriptor_status_word, next_stat;
  logic [15:0] descriptor_buffer_pointer, next_ptr;
  logic [7:0]  top_interrupt_status, next_top;
  logic [7:0]  otg_interrupt_status, next_otg;
  logic [7:0]  otg_line_power_control, next_pwr;
  logic [7:0]  module_config_two, next_cfg;
  logic [31:0] rdata, next_rdata;
  logic        rd_pend, next_rd_pend;
  uotg_pkg::uotg_state_e state, next_state;
  logic [7:0]  act_tok, next_act_tok;
  logic        tok_pend, next_tok_pend;
  logic        ctrl_used, next_ctrl_used;
  logic [FW-1:0] frame_cnt, next_frame_cnt;
  logic        det_q, next_det_q, sv_q, next_sv_q, se_q, next_se_q;
  logic        detached, next_detached;
  logic [3:0]  pins_s;
  logic        se0;
  logic        wr_lane0, wr_lane1, tok_wr, launch_ok, fin;
  logic [7:0]  top_set, otg_set, top_clr, otg_clr;

  uotg_cnt_if se0_if ();
  uotg_cnt_if idle_if ();

  // pins pass two flip-flops before use
  uotg_sync #(.W(4)) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d       ({line_dp, line_dm, vbus_sess_valid, vbus_sess_end}),
    .q       (pins_s)
  );

  assign se0 = !pins_s[3] && !pins_s[2];
  assign se0_if.run  = se0;
  assign idle_if.run = se0;

  // detach hold time on single-ended zero
  uotg_hold_timer #(.LIMIT(uotg_pkg::DETACH_CYCLES)) u_se0 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ctl     (se0_if.tmr)
  );
  // both lines low for the idle time
  uotg_hold_timer #(.LIMIT(IDLE_CYCLES)) u_idle (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ctl     (idle_if.tmr)
  );

  // bus decode: writes take no wait, reads one
  assign wr_lane0        = avs_write && avs_byteenable[0];
  assign wr_lane1        = avs_write && avs_byteenable[1];
  assign tok_wr          = wr_lane0 && (avs_address == uotg_pkg::IDX_TOKEN);
  assign avs_waitrequest = avs_read && !rd_pend;
  assign avs_readdata    = rdata;
  assign frame_start     = (frame_cnt == FRAME_LAST);

  // transaction engine and descriptor write-back
  assign launch_ok = tok_pend
                  && descriptor_status_word[uotg_pkg::OWN_BIT]
                  && !(token_issue_register[7:4] == uotg_pkg::PID_SETUP && ctrl_used);
  assign fin = (state == uotg_pkg::UOTG_WAIT) && res_valid
            && !(res_pid == uotg_pkg::PID_NAK
                 && !endpoint_zero_control[uotg_pkg::RETRY_DIS_BIT]);
  always_comb begin
    next_state     = state;
    next_act_tok   = act_tok;
    next_tok_pend  = tok_pend || tok_wr;
    next_ctrl_used = frame_start ? 1'b0 : ctrl_used;
    top_set        = 8'h00;
    unique case (state)
      uotg_pkg::UOTG_IDLE: begin
        if (launch_ok) begin
          next_state    = uotg_pkg::UOTG_SEND;
          next_act_tok  = token_issue_register;
          next_tok_pend = tok_wr;
        end
      end
      uotg_pkg::UOTG_SEND: begin
        if (pkt_ready) begin
          next_state = uotg_pkg::UOTG_WAIT;
        end
      end
      uotg_pkg::UOTG_WAIT: begin
        if (res_valid) begin
          next_state = fin ? uotg_pkg::UOTG_IDLE : uotg_pkg::UOTG_SEND;
        end
        if (fin) begin
          top_set[uotg_pkg::TRN_DONE_BIT] = 1'b1;
          top_set[uotg_pkg::STALL_BIT]    = (res_pid == uotg_pkg::PID_STALL);
          if (act_tok[7:4] == uotg_pkg::PID_SETUP) begin
            next_ctrl_used = 1'b1;
          end
        end
      end
      default: begin
        next_state = uotg_pkg::UOTG_IDLE;
      end
    endcase
    // line events share the one driver of the top flag set vector
    top_set[uotg_pkg::DETACH_BIT] = se0_if.done && !det_q;
    top_set[uotg_pkg::ATTACH_BIT] = detached && !se0;
  end

  // link-side request fields
  assign pkt_valid     = (state == uotg_pkg::UOTG_SEND);
  assign pkt_pid       = act_tok[7:4];
  assign pkt_endp      = act_tok[3:0];
  assign pkt_addr      = target_address_register[6:0];
  assign pkt_toggle    = descriptor_status_word[uotg_pkg::TOGGLE_BIT];
  assign pkt_count     = descriptor_status_word[uotg_pkg::COUNT_W-1:0];
  assign pkt_buf_ptr   = descriptor_buffer_pointer;
  assign pkt_low_speed = endpoint_zero_control[uotg_pkg::LOW_SPEED_BIT];
  assign pkt_handshake = endpoint_zero_control[uotg_pkg::EP_HSHK_BIT];

  // line, session and frame events
  always_comb begin
    next_det_q     = se0_if.done;
    next_sv_q      = pins_s[1];
    next_se_q      = pins_s[0];
    next_detached  = detached;
    next_frame_cnt = frame_start ? '0 : frame_cnt + FW'(1);
    otg_set        = 8'h00;
    top_clr        = 8'h00;
    otg_clr        = 8'h00;
    if (se0_if.done && !det_q) begin
      next_detached = 1'b1;
    end else if (detached && !se0) begin
      next_detached = 1'b0;
    end
    otg_set[uotg_pkg::SESS_VLD_BIT] = pins_s[1] && !sv_q;
    otg_set[uotg_pkg::SESS_END_BIT] = pins_s[0] && !se_q;
    if (wr_lane0 && avs_address == uotg_pkg::IDX_TOP_IRQ) begin
      top_clr = avs_writedata[7:0];
    end
    if (wr_lane0 && avs_address == uotg_pkg::IDX_OTG_IRQ) begin
      otg_clr = avs_writedata[7:0];
    end
  end

  // register file; hardware set and write-back win over software
  always_comb begin
    next_ep0  = endpoint_zero_control;
    next_addr = target_address_register;
    next_tok  = token_issue_register;
    next_stat = descriptor_status_word;
    next_ptr  = descriptor_buffer_pointer;
    next_pwr  = otg_line_power_control;
    next_cfg  = module_config_two;
    if (wr_lane0) begin
      case (avs_address)
        uotg_pkg::IDX_EP0_CTRL:  next_ep0  = avs_writedata[7:0];
        uotg_pkg::IDX_TGT_ADDR:  next_addr = avs_writedata[7:0];
        uotg_pkg::IDX_TOKEN:     next_tok  = avs_writedata[7:0];
        uotg_pkg::IDX_DESC_STAT: next_stat[7:0] = avs_writedata[7:0];
        uotg_pkg::IDX_DESC_PTR:  next_ptr[7:0]  = avs_writedata[7:0];
        uotg_pkg::IDX_OTG_PWR:   next_pwr  = avs_writedata[7:0];
        uotg_pkg::IDX_CFG_TWO:   next_cfg  = avs_writedata[7:0];
        default: ;
      endcase
    end
    if (wr_lane1 && avs_address == uotg_pkg::IDX_DESC_STAT) begin
      next_stat[15:8] = avs_writedata[15:8];
    end
    if (wr_lane1 && avs_address == uotg_pkg::IDX_DESC_PTR) begin
      next_ptr[15:8] = avs_writedata[15:8];
    end
    if (fin) begin
      next_stat = {1'b0, descriptor_status_word[uotg_pkg::TOGGLE_BIT],
                   res_pid, res_count};
    end
    next_top = (top_interrupt_status & ~top_clr) | top_set;
    next_otg = (otg_interrupt_status & ~otg_clr) | otg_set;
    next_rd_pend = avs_read && !rd_pend;
    next_rdata   = rdata;
    if (avs_read && !rd_pend) begin
      case (avs_address)
        uotg_pkg::IDX_EP0_CTRL:  next_rdata = {24'h0, endpoint_zero_control};
        uotg_pkg::IDX_TGT_ADDR:  next_rdata = {24'h0, target_address_register};
        uotg_pkg::IDX_TOKEN:     next_rdata = {24'h0, token_issue_register};
        uotg_pkg::IDX_DESC_STAT: next_rdata = {16'h0, descriptor_status_word};
        uotg_pkg::IDX_DESC_PTR:  next_rdata = {16'h0, descriptor_buffer_pointer};
        uotg_pkg::IDX_TOP_IRQ:   next_rdata = {24'h0, top_interrupt_status};
        uotg_pkg::IDX_OTG_IRQ:   next_rdata = {24'h0, otg_interrupt_status};
        uotg_pkg::IDX_OTG_PWR:   next_rdata = {24'h0, otg_line_power_control};
        uotg_pkg::IDX_CFG_TWO:   next_rdata = {24'h0, module_config_two};
        uotg_pkg::IDX_LINE_STAT: next_rdata = {24'h0, state != uotg_pkg::UOTG_IDLE,
                                   3'h0, pins_s[1], pins_s[0], idle_if.done, se0};
        default:                 next_rdata = 32'h0;
      endcase
    end
  end

  // pad controls straight from the power register; vbus_pulse from module_config_two
  assign dplus_pullup   = otg_line_power_control[uotg_pkg::DP_PU_BIT];
  assign dminus_pullup  = otg_line_power_control[uotg_pkg::DM_PU_BIT];
  assign vbus_power     = otg_line_power_control[uotg_pkg::VBUS_ON_BIT];
  assign vbus_discharge = otg_line_power_control[uotg_pkg::VBUS_DIS_BIT];
  assign vbus_pulse     = module_config_two[uotg_pkg::VBUS_PULSE_BIT];

  // state registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      endpoint_zero_control     <= 8'h00;
      target_address_register   <= 8'h00;
      token_issue_register      <= 8'h00;
      descriptor_status_word    <= 16'h0000;
      descriptor_buffer_pointer <= 16'h0000;
      top_interrupt_status      <= 8'h00;
      otg_interrupt_status      <= 8'h00;
      otg_line_power_control    <= 8'h00;
      module_config_two         <= 8'h00;
      rdata                     <= 32'h0;
      rd_pend                   <= 1'b0;
      state                     <= uotg_pkg::UOTG_IDLE;
      act_tok                   <= 8'h00;
      tok_pend                  <= 1'b0;
      ctrl_used                 <= 1'b0;
      frame_cnt                 <= '0;
      det_q                     <= 1'b0;
      sv_q                      <= 1'b0;
      se_q                      <= 1'b0;
      detached                  <= 1'b1;
    end else begin
      endpoint_zero_control     <= next_ep0;
      target_address_register   <= next_addr;
      token_issue_register      <= next_tok;
      descriptor_status_word    <= next_stat;
      descriptor_buffer_pointer <= next_ptr;
      top_interrupt_status      <= next_top;
      otg_interrupt_status      <= next_otg;
      otg_line_power_control    <= next_pwr;
      module_config_two         <= next_cfg;
      rdata                     <= next_rdata;
      rd_pend                   <= next_rd_pend;
      state                     <= next_state;
      act_tok                   <= next_act_tok;
      tok_pend                  <= next_tok_pend;
      ctrl_used                 <= next_ctrl_used;
      frame_cnt                 <= next_frame_cnt;
      det_q                     <= next_det_q;
      sv_q                      <= next_sv_q;
      se_q                      <= next_se_q;
      detached                  <= next_detached;
    end
  end

  // checks on the engine, flags and pads
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_own_before_send: assert property ($rose(pkt_valid) |->
    $past(descriptor_status_word[uotg_pkg::OWN_BIT])) else $error("send without ownership");
  a_done_flag_set: assert property (fin |=>
    top_interrupt_status[uotg_pkg::TRN_DONE_BIT]) else $error("done flag missing");
  a_desc_released: assert property (fin |=> !descriptor_status_word[uotg_pkg::OWN_BIT]
    && descriptor_status_word[13:10] == $past(res_pid)) else $error("bad write-back");
  a_nak_retry: assert property (state == uotg_pkg::UOTG_WAIT && res_valid
    && res_pid == uotg_pkg::PID_NAK && !endpoint_zero_control[uotg_pkg::RETRY_DIS_BIT]
    |=> pkt_valid && descriptor_status_word[uotg_pkg::OWN_BIT]) else $error("nak not retried");
  a_one_ctrl_frame: assert property (pkt_valid && pkt_pid == uotg_pkg::PID_SETUP
    && $rose(pkt_valid) |-> !$past(ctrl_used)) else $error("second setup in frame");
  a_detach_flag: assert property ($rose(se0_if.done) |=>
    top_interrupt_status[uotg_pkg::DETACH_BIT]) else $error("detach not flagged");
  a_detach_hold: assert property ($rose(se0_if.done) |->
    $past(se0, uotg_pkg::DETACH_CYCLES)) else $error("detach too early");
  a_w1c_clear: assert property (wr_lane0 && avs_address == uotg_pkg::IDX_TOP_IRQ
    && !top_set[uotg_pkg::DETACH_BIT] ##0 avs_writedata[uotg_pkg::DETACH_BIT]
    |=> !top_interrupt_status[uotg_pkg::DETACH_BIT]) else $error("w1c failed");
  a_w0_keeps: assert property (wr_lane0 && avs_address == uotg_pkg::IDX_TOP_IRQ
    && !avs_writedata[uotg_pkg::TRN_DONE_BIT] && top_interrupt_status[uotg_pkg::TRN_DONE_BIT]
    |=> top_interrupt_status[uotg_pkg::TRN_DONE_BIT]) else $error("zero cleared flag");
  a_vbus_off: assert property (wr_lane0 && avs_address == uotg_pkg::IDX_OTG_PWR
    && !avs_writedata[uotg_pkg::VBUS_ON_BIT] |=> !vbus_power) else $error("vbus kept");
  a_sess_valid: assert property ($rose(pins_s[1]) |=>
    otg_interrupt_status[uotg_pkg::SESS_VLD_BIT]) else $error("session valid lost");

  c_setup_done: cover property (pkt_valid && act_tok == uotg_pkg::TOK_SETUP_EP0
    && descriptor_status_word == uotg_pkg::STAT_SETUP8 ##[1:200] fin);
  c_in_data1: cover property (pkt_valid && act_tok == uotg_pkg::TOK_IN_EP0
    && descriptor_status_word == uotg_pkg::STAT_DATA1_64);
  c_out_status: cover property (pkt_valid && act_tok == uotg_pkg::TOK_OUT_EP0
    && descriptor_status_word == uotg_pkg::STAT_DATA0_0);
  c_nak_retry: cover property (res_valid && res_pid == uotg_pkg::PID_NAK ##1 pkt_valid);
  c_detach: cover property ($rose(top_interrupt_status[uotg_pkg::DETACH_BIT]));
endmodule // uotg_host_srp
`default_nettype wire

// File: design/uotg_pkg.sv
package uotg_pkg;
  // clock rate and link timings
  localparam int  CLK_MHZ          = 200;
  localparam real DETACH_US        = 2.5;
  localparam int  DETACH_CYCLES    = int'($ceil(DETACH_US * real'(CLK_MHZ)));
  localparam int  IDLE_MS          = 2;
  localparam int  IDLE_CYCLES      = IDLE_MS * 1000 * CLK_MHZ;
  localparam int  FRAME_MS         = 1;
  localparam int  FRAME_CYCLES     = FRAME_MS * 1000 * CLK_MHZ;

  // register word indices (byte address = 4 * index)
  localparam logic [3:0] IDX_EP0_CTRL  = 4'h0;
  localparam logic [3:0] IDX_TGT_ADDR  = 4'h1;
  localparam logic [3:0] IDX_TOKEN     = 4'h2;
  localparam logic [3:0] IDX_DESC_STAT = 4'h3;
  localparam logic [3:0] IDX_DESC_PTR  = 4'h4;
  localparam logic [3:0] IDX_TOP_IRQ   = 4'h5;
  localparam logic [3:0] IDX_OTG_IRQ   = 4'h6;
  localparam logic [3:0] IDX_OTG_PWR   = 4'h7;
  localparam logic [3:0] IDX_CFG_TWO   = 4'h8;
  localparam logic [3:0] IDX_LINE_STAT = 4'h9;

  // endpoint_zero_control bits
  localparam int EP_HSHK_BIT   = 0;
  localparam int EP_TX_BIT     = 2;
  localparam int EP_CONDIS_BIT = 3;
  localparam int EP_RX_BIT     = 4;
  localparam int RETRY_DIS_BIT = 6;
  localparam int LOW_SPEED_BIT = 7;
  // descriptor_status_word fields
  localparam int OWN_BIT       = 15;
  localparam int TOGGLE_BIT    = 14;
  localparam int PID_LSB       = 10;
  localparam int COUNT_W       = 10;
  // top_interrupt_status bits
  localparam int DETACH_BIT    = 0;
  localparam int TRN_DONE_BIT  = 3;
  localparam int ATTACH_BIT    = 6;
  localparam int STALL_BIT     = 7;
  // otg_interrupt_status / line status bits
  localparam int SESS_END_BIT  = 2;
  localparam int SESS_VLD_BIT  = 3;
  localparam int LINE_IDLE_BIT = 1;
  localparam int BUSY_BIT      = 7;
  // otg_line_power_control and module_config_two bits
  localparam int DP_PU_BIT     = 7;
  localparam int DM_PU_BIT     = 6;
  localparam int VBUS_ON_BIT   = 3;
  localparam int VBUS_DIS_BIT  = 0;
  localparam int VBUS_PULSE_BIT = 4;

  // packet identifiers
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_IN    = 4'h9;
  localparam logic [3:0] PID_OUT   = 4'h1;
  localparam logic [3:0] PID_ACK   = 4'h2;
  localparam logic [3:0] PID_NAK   = 4'ha;
  localparam logic [3:0] PID_STALL = 4'he;
  localparam logic [3:0] PID_ERROR = 4'hf;

  // typical software values for a control transfer
  localparam logic [7:0]  EP0_CTRL_PIPE = 8'h0d;
  localparam logic [7:0]  EP0_BULK_PIPE = 8'h1d;
  localparam logic [15:0] STAT_SETUP8   = 16'h8008;
  localparam logic [15:0] STAT_DATA1_64 = 16'hc040;
  localparam logic [15:0] STAT_DATA0_0  = 16'h8000;
  localparam logic [7:0]  TOK_SETUP_EP0 = 8'hd0;
  localparam logic [7:0]  TOK_IN_EP0    = 8'h90;
  localparam logic [7:0]  TOK_OUT_EP0   = 8'h01;

  typedef enum logic [1:0] {
    UOTG_IDLE = 2'b00,
    UOTG_SEND = 2'b01,
    UOTG_WAIT = 2'b10
  } uotg_state_e;
endpackage

// File: design/uotg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module uotg_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,  // clock
  input  wire logic         resetn,   // async reset
  input  wire logic [W-1:0] d,        // pin levels
  output logic      [W-1:0] q         // synchronised levels
);
  logic [W-1:0] meta;

  // two flip-flop synchroniser
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // uotg_sync
`default_nettype wire

// File: tb/uotg_host_srp_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uotg_host_srp_tb;
  logic        ref_clk = 0, resetn = 0, avs_read = 0, avs_write = 0;
  logic        line_dp = 1, line_dm = 0, vbus_sess_valid = 0, vbus_sess_end = 0;
  logic [3:0]  avs_address = 0, rsp_pid = uotg_pkg::PID_ACK, rsp_wait = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic        avs_waitrequest, pkt_valid, pkt_ready, pkt_toggle, pkt_low_speed, pkt_handshake;
  logic        res_valid, frame_start, dplus_pullup, dminus_pullup, vbus_power;
  logic        vbus_discharge, vbus_pulse;
  logic [3:0]  pkt_pid, pkt_endp, res_pid;
  logic [6:0]  pkt_addr;
  logic [9:0]  pkt_count, res_count;
  logic [15:0] pkt_buf_ptr;
  logic [26:0] cap;
  logic [15:0] capp;
  logic [31:0] irq;
  logic [15:0] st [4] = '{uotg_pkg::STAT_SETUP8, uotg_pkg::STAT_SETUP8,
                          uotg_pkg::STAT_DATA1_64, uotg_pkg::STAT_DATA0_0};
  logic [7:0]  tk [4] = '{uotg_pkg::TOK_SETUP_EP0, uotg_pkg::TOK_SETUP_EP0,
                          uotg_pkg::TOK_IN_EP0, uotg_pkg::TOK_OUT_EP0};
  logic [3:0]  hs [3] = '{uotg_pkg::PID_NAK, uotg_pkg::PID_STALL, uotg_pkg::PID_ERROR};
  int          n_fail = 0, total_checks = 0, nl = 0, fr = 0, capf = 0, fw, n0, i;

  uotg_host_srp #(.IDLE_CYCLES(50), .FRAME_CYCLES(300)) i_uotg_host_srp (
    .ref_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .pkt_valid, .pkt_ready,
    .pkt_pid, .pkt_endp, .pkt_addr, .pkt_toggle, .pkt_count, .pkt_buf_ptr, .pkt_low_speed,
    .pkt_handshake, .res_valid, .res_pid, .res_count, .frame_start, .line_dp, .line_dm,
    .vbus_sess_valid, .vbus_sess_end, .dplus_pullup, .dminus_pullup, .vbus_power,
    .vbus_discharge, .vbus_pulse);
  uotg_link_model i_uotg_link_model (.ref_clk, .resetn, .pkt_valid, .pkt_count, .rsp_pid,
    .rsp_wait, .pkt_ready, .res_valid, .res_pid, .res_count);

  always #2.5 ref_clk = ~ref_clk;
  // count frames and capture each launched request
  always @(negedge ref_clk) begin
    if (frame_start) fr++;
    if (pkt_valid && pkt_ready) begin
      nl++;
      capf = fr;
      cap = {pkt_handshake, pkt_addr, pkt_pid, pkt_endp, pkt_toggle, pkt_count};
      capp = pkt_buf_ptr;
    end
  end

  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin n_fail++; $display("BAD %0t got %h exp %h", $time, g, e); end
  endtask
  // one avalon transfer, held until waitrequest is low
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    int t;
    avs_address <= a;
    avs_writedata <= {16'h0, d};
    avs_write <= w;
    avs_read <= !w;
    t = 0;
    // waitrequest looked at on the rising edge that completes the transfer
    do begin
      @(posedge ref_clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      $display("BAD %0t bus hang", $time);
      final_report();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e); bus(0, a, 0); chk(q, e); endtask
  task automatic cy(input int n); repeat (n) @(posedge ref_clk); endtask
  // poll for transfer done, then clear all top interrupt flags
  task automatic w8();
    int t;
    for (t = 0; t < 150; t++) begin bus(0, 5, 0); if (q[3] === 1'b1) break; end
    if (t == 150) begin n_fail++; $display("BAD %0t no done", $time); final_report(); end
    irq = q;
    bus(1, 5, 16'hff);
  endtask

  initial begin
    cy(16); resetn <= 1'b1; cy(8);
    rc(5, 32'h40); bus(1, 5, 16'h00); rc(5, 32'h40);
    bus(1, 5, 16'h40); rc(5, 32'h00);
    bus(1, 0, 16'h0d); bus(1, 1, 16'h05); bus(1, 4, 16'h1234);
    // setup twice, data and status phases
    for (i = 0; i < 4; i++) begin
      rsp_wait <= 4'(i * 5); bus(1, 3, st[i]); fw = fr; bus(1, 2, tk[i]); w8();
      chk(cap, {1'b1, 7'h05, tk[i], st[i][14], st[i][9:0]});
      chk(capp, 32'h1234);
      rc(3, {17'h0, st[i][14], uotg_pkg::PID_ACK, st[i][9:0]});
      if (i == 1) chk(capf > fw, 1);
    end
    // nak retried until ack
    bus(1, 0, 16'h1d); rsp_pid <= uotg_pkg::PID_NAK; bus(1, 3, 16'h8000); n0 = nl;
    bus(1, 2, 16'h01); cy(60); rc(5, 0); rc(3, 32'h8000); chk(nl - n0 > 2, 1);
    rsp_pid <= uotg_pkg::PID_ACK; w8(); rc(3, 32'h0800);
    // retry disabled: every handshake recorded
    bus(1, 0, 16'hdd);
    for (i = 0; i < 3; i++) begin
      rsp_pid <= hs[i]; bus(1, 3, 16'h8000); bus(1, 2, 16'h01); w8();
      chk(irq[7:0], (hs[i] == uotg_pkg::PID_STALL) ? 32'h88 : 32'h08);
      rc(3, {18'h0, hs[i], 10'h0}); chk(pkt_low_speed, 1);
    end
    // token waits for ownership
    bus(1, 3, 16'h0000); n0 = nl; bus(1, 2, 16'h01); cy(40); chk(nl - n0, 0);
    bus(1, 3, 16'h8000); w8(); chk(nl - n0, 1);
    // power and session lines
    bus(1, 7, 16'hc9); bus(1, 8, 16'h10);
    chk({dplus_pullup, dminus_pullup, vbus_power, vbus_discharge, vbus_pulse}, 5'h1f);
    bus(1, 7, 16'h00); chk(vbus_power, 0);
    vbus_sess_end <= 1'b1; vbus_sess_valid <= 1'b1; cy(6); rc(6, 32'h0c);
    bus(1, 6, 16'h0c); rc(6, 0);
    // single-ended zero: detach only after the hold time
    line_dp <= 1'b0; cy(400); rc(5, 0); cy(150); rc(5, 1); rc(9, 32'h0f);
    final_report();
  end
endmodule // uotg_host_srp_tb
`default_nettype wire

// File: tb/uotg_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side link: takes a request, answers after a delay
module uotg_link_model (
  input  wire logic       ref_clk,    // clock
  input  wire logic       resetn,     // async reset
  input  wire logic       pkt_valid,  // request from host
  input  wire logic [9:0] pkt_count,  // bytes asked for
  input  wire logic [3:0] rsp_pid,    // handshake to return
  input  wire logic [3:0] rsp_wait,   // answer delay in cycles
  output logic            pkt_ready,  // request taken
  output logic            res_valid,  // result pulse
  output logic      [3:0] res_pid,    // result pid
  output logic      [9:0] res_count   // bytes moved
);
  logic [4:0] cnt;  // cycles left to answer, zero when idle
  // accept only when no answer is outstanding
  assign pkt_ready = pkt_valid && (cnt == 5'h0);
  // result pulse; pid inverts each cycle outside it so stale values match only every other cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt       <= 5'h0;
      res_valid <= 1'b0;
      res_pid   <= 4'h0;
      res_count <= 10'h0;
    end else begin
      res_valid <= 1'b0;
      res_pid   <= ~res_pid;
      if (pkt_valid && pkt_ready) begin
        cnt <= {1'b0, rsp_wait} + 5'h1;
      end else if (cnt == 5'h1) begin
        res_valid <= 1'b1;
        res_pid   <= rsp_pid;
        res_count <= pkt_count;
        cnt       <= 5'h0;
      end else if (cnt != 5'h0) begin
        cnt <= cnt - 5'h1;
      end
    end
  end
endmodule // uotg_link_model
`default_nettype wire
